// ==== core/energy_pulse_regs.vh ====
// Constants for the energy pulse output and sag detect block
`ifndef ENERGY_PULSE_REGS_VH
`define ENERGY_PULSE_REGS_VH

// Divided master clock cycles in one output word period
`define EPO_OWR_DCLKS 11'h400
`define EPO_OWR_CNT_W 11

// Modes of the third energy output pin
`define EPO_E3_REACTIVE 2'b00
`define EPO_E3_SUPPLY 2'b01
`define EPO_E3_VSIGN 2'b10
`define EPO_E3_APPARENT 2'b11

// Mode of the sign/apparent pin
`define EPO_E2_SIGN 1'b0
`define EPO_E2_APPARENT 1'b1

// Accumulator bit that marks full scale: product of two 24-bit fractions
// is scaled by 2^46, and one pulse per two word periods at full scale
`define EPO_ACC_FULL_BIT 47

// Pending pulse count saturates here
`define EPO_PEND_W 4
`define EPO_PEND_MAX 4'hf

// Shortest low time in word periods
`define EPO_MIN_LOW 16'h0001

// Reset levels
`define EPO_PIN_IDLE 1'b1
`define EPO_SIGN_POS 1'b1
`define EPO_FLAG_RST 1'b0

// Sign bit of the 24-bit two's complement results
`define EPO_SIGN_BIT 23

`endif

// ==== core/energy_pulse_gen.v ====
// One energy-to-pulse converter with a rate limiter
`timescale 1ns/10ps
`include "energy_pulse_regs.vh"

module energy_pulse_gen #(
  parameter MAG_W = 24,
  parameter SCALE_W = 24,
  parameter WIDTH_W = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Control
  input wire enable,
  input wire owr_tick,
  input wire [MAG_W-1:0] magnitude,
  input wire [SCALE_W-1:0] scale,
  input wire [WIDTH_W-1:0] width,
  // Firing handshake
  input wire fire,
  output wire ready,
  // Active-low pulse
  output reg pulse_n
);

  localparam ACC_W = MAG_W + SCALE_W + 1;
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOW = 2'b01;
  localparam [1:0] ST_GAP = 2'b10;

  reg [1:0] state;
  reg [ACC_W-1:0] acc;
  reg [`EPO_PEND_W-1:0] pending;
  reg [WIDTH_W-1:0] low_cnt;
  reg [1:0] next_state;
  reg [ACC_W-1:0] next_acc;
  reg [`EPO_PEND_W-1:0] next_pending;
  reg [WIDTH_W-1:0] next_low_cnt;
  reg crossed;
  wire [MAG_W+SCALE_W-1:0] product;
  wire [ACC_W-1:0] incr;
  wire [ACC_W-1:0] acc_sum;
  wire [ACC_W-1:0] acc_full;

  // Product sized on its own net; inside a concatenation it would be cut
  assign product = magnitude * scale;
  assign incr = {1'b0, product};
  assign acc_sum = acc + incr;
  assign acc_full = {{(ACC_W-1){1'b0}}, 1'b1} << `EPO_ACC_FULL_BIT;
  // Starts only on a word period boundary, so low plus gap spans at least two
  assign ready = ((state == ST_IDLE) || (state == ST_GAP)) &&
    (pending != 0) && owr_tick; // R4

  always @* begin
    next_acc = acc;
    crossed = 1'b0;
    next_pending = pending;
    next_state = state;
    next_low_cnt = low_cnt;
    if (!enable) begin
      next_acc = {ACC_W{1'b0}};
      next_pending = {`EPO_PEND_W{1'b0}};
    end else if (owr_tick) begin
      // Scaled power summed once per word period
      if (acc_sum >= acc_full) begin // R19
        next_acc = acc_sum - acc_full;
        crossed = 1'b1;
      end else begin
        next_acc = acc_sum;
      end
    end
    if (enable && fire && ready) begin
      next_pending = next_pending - 1'b1;
    end
    if (crossed && next_pending != `EPO_PEND_MAX) begin
      next_pending = next_pending + 1'b1; // R19
    end
    case (state)
      ST_IDLE: begin
        if (enable && fire && ready) begin
          next_state = ST_LOW;
          next_low_cnt = (width == 0) ? `EPO_MIN_LOW : width; // R18
        end
      end
      ST_LOW: begin
        if (owr_tick) begin
          if (low_cnt == `EPO_MIN_LOW) begin
            next_state = ST_GAP; // R20
          end else begin
            next_low_cnt = low_cnt - 1'b1; // R18
          end
        end
      end
      ST_GAP: begin
        // Back-to-back pulses keep the pin high for exactly one word period
        if (enable && fire && ready) begin
          next_state = ST_LOW;
          next_low_cnt = (width == 0) ? `EPO_MIN_LOW : width; // R18
        end else if (owr_tick) begin
          next_state = ST_IDLE; // R20
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      acc <= {ACC_W{1'b0}};
      pending <= {`EPO_PEND_W{1'b0}};
      low_cnt <= {WIDTH_W{1'b0}};
      pulse_n <= `EPO_PIN_IDLE;
    end else begin
      state <= next_state;
      acc <= next_acc;
      pending <= next_pending;
      low_cnt <= next_low_cnt;
      pulse_n <= (next_state != ST_LOW); // R20
    end
  end

endmodule // energy_pulse_gen

// ==== core/energy_pulse_output.v ====
// Energy pulse outputs, pin modes, no-load inhibit and sag detection
//
// Overview of operation
// [R1] Active energy pin pulses low at a rate proportional to active power.
// [R2] Sign mode: sign pin high for positive, low negative, at active fall.
// [R3] Rate is scale times divided clock over 2048 at full scale.
// [R4] No pulse output ever exceeds divided clock over 2048.
// [R5] Second select at one puts apparent pulses on the sign pin.
// [R6] Third select 11 puts apparent pulses on the third pin.
// [R7] Apparent pulses follow apparent power and carry no direction.
// [R8] Third select 00 puts reactive power pulses on the third pin.
// [R9] Reactive sign shown by the sign pin level at third pin fall.
// [R10] Third select 10 shows line voltage polarity on the third pin.
// [R11] Third select 01 shows supply monitor comparator on the third pin.
// [R12] Voltage sag sets voltage flag; current sag sets current flag.
// [R13] Sag declared when below level for over half the window.
// [R14] Software sets level and window before a detector becomes active.
// [R15] Level compared to absolute samples; window counted in samples.
// [R16] Active pulses suppressed while active power is below no-load level.
// [R17] Default second select zero: sign pin shows active and reactive sign.
// [R18] Low time lasts pulse width count word periods of 1024 clocks.
// [R19] Accumulate scaled power per word period; pulse at each full scale.
// [R20] Pins rest high; a pulse ends before the next on that pin.
`timescale 1ns/10ps
`include "energy_pulse_regs.vh"

module energy_pulse_output #(
  parameter CLK_DIV_K = 4'h1,
  parameter DATA_W = 24,
  parameter WIDTH_W = 16,
  parameter WINDOW_W = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Output mode configuration
  input wire second_output_select,
  input wire [1:0] third_output_select,
  input wire [DATA_W-1:0] pulse_rate_scale,
  input wire [WIDTH_W-1:0] pulse_width_count,
  input wire [DATA_W-1:0] no_load_threshold,
  // Sag and fault configuration
  input wire [DATA_W-1:0] voltage_sag_threshold,
  input wire [WINDOW_W-1:0] voltage_sag_window,
  input wire [DATA_W-1:0] current_fault_threshold,
  input wire [WINDOW_W-1:0] current_fault_window,
  // Power results, two's complement except apparent
  input wire [DATA_W-1:0] active_power_result,
  input wire [DATA_W-1:0] apparent_power_result,
  input wire [DATA_W-1:0] reactive_power_result,
  // Instantaneous samples, two's complement
  input wire [DATA_W-1:0] voltage_sample,
  input wire [DATA_W-1:0] current_sample,
  // Supply monitor comparator pin
  input wire supply_monitor_input,
  // Status flags and their clears
  input wire voltage_sag_clear,
  input wire current_fault_clear,
  output reg voltage_sag_flag,
  output reg current_fault_flag,
  // Energy pins, active low pulses
  output reg active_energy_pulse_pin,
  output reg sign_or_apparent_pin,
  output reg third_energy_output_pin
);

  // Clock divider and word period timing
  reg [3:0] div_cnt;
  reg dclk_en;
  reg [`EPO_OWR_CNT_W-1:0] owr_cnt;
  reg owr_tick;

  // Supply monitor synchroniser
  reg supply_meta;
  reg supply_sync;

  // Shared energy sign, 1 means positive
  reg energy_sign;
  reg next_sign;

  // Generator handshakes
  wire rdy_act;
  wire rdy_app;
  wire rdy_rea;
  wire act_n;
  wire app_n;
  wire rea_n;
  reg fire_act;
  reg fire_rea;

  // Magnitudes
  wire [DATA_W-1:0] act_mag;
  wire [DATA_W-1:0] rea_mag;
  wire [DATA_W-1:0] act_feed;
  wire no_load;
  wire act_pos;
  wire rea_pos;
  wire app_en;
  wire rea_en;

  // Sag detectors, index 0 voltage, 1 current
  wire [DATA_W-1:0] sag_mag [0:1];
  wire [DATA_W-1:0] sag_level [0:1];
  wire [WINDOW_W-1:0] sag_win [0:1];
  wire [1:0] sag_clear;
  wire [1:0] sag_event;

  function [DATA_W-1:0] abs_val;
    input [DATA_W-1:0] v;
    begin
      abs_val = v[`EPO_SIGN_BIT] ? (~v + 1'b1) : v;
    end
  endfunction

  // Divided master clock enable, then one tick per word period
  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= 4'h0;
      dclk_en <= 1'b0;
    end else if (div_cnt >= CLK_DIV_K - 4'h1) begin
      div_cnt <= 4'h0;
      dclk_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      dclk_en <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      owr_cnt <= {`EPO_OWR_CNT_W{1'b0}};
      owr_tick <= 1'b0;
    end else begin
      owr_tick <= 1'b0;
      if (dclk_en) begin
        if (owr_cnt == `EPO_OWR_DCLKS - 1'b1) begin
          owr_cnt <= {`EPO_OWR_CNT_W{1'b0}};
          owr_tick <= 1'b1; // R18
        end else begin
          owr_cnt <= owr_cnt + 1'b1;
        end
      end
    end
  end

  // Comparator arrives from the analog side, so it is synchronised
  always @(posedge core_clk) begin
    if (srst) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      supply_meta <= supply_monitor_input;
      supply_sync <= supply_meta;
    end
  end

  assign act_mag = abs_val(active_power_result);
  assign rea_mag = abs_val(reactive_power_result);
  assign no_load = (act_mag < no_load_threshold); // R16
  assign act_feed = no_load ? {DATA_W{1'b0}} : act_mag; // R16
  assign act_pos = ~active_power_result[`EPO_SIGN_BIT];
  assign rea_pos = ~reactive_power_result[`EPO_SIGN_BIT];
  assign app_en = (second_output_select == `EPO_E2_APPARENT) ||
    (third_output_select == `EPO_E3_APPARENT); // R5 R6
  assign rea_en = (third_output_select == `EPO_E3_REACTIVE); // R8

  // Active energy
  energy_pulse_gen #(
    .MAG_W(DATA_W),
    .SCALE_W(DATA_W),
    .WIDTH_W(WIDTH_W)
  ) u_active (
    .core_clk(core_clk),
    .srst(srst),
    .enable(1'b1),
    .owr_tick(owr_tick),
    .magnitude(act_feed),
    .scale(pulse_rate_scale),
    .width(pulse_width_count),
    .fire(fire_act),
    .ready(rdy_act),
    .pulse_n(act_n)
  ); // R1 R3

  // Apparent energy, unsigned, so never waits on the sign
  energy_pulse_gen #(
    .MAG_W(DATA_W),
    .SCALE_W(DATA_W),
    .WIDTH_W(WIDTH_W)
  ) u_apparent (
    .core_clk(core_clk),
    .srst(srst),
    .enable(app_en),
    .owr_tick(owr_tick),
    .magnitude(apparent_power_result),
    .scale(pulse_rate_scale),
    .width(pulse_width_count),
    .fire(rdy_app),
    .ready(rdy_app),
    .pulse_n(app_n)
  ); // R7

  // Reactive energy
  energy_pulse_gen #(
    .MAG_W(DATA_W),
    .SCALE_W(DATA_W),
    .WIDTH_W(WIDTH_W)
  ) u_reactive (
    .core_clk(core_clk),
    .srst(srst),
    .enable(rea_en),
    .owr_tick(owr_tick),
    .magnitude(rea_mag),
    .scale(pulse_rate_scale),
    .width(pulse_width_count),
    .fire(fire_rea),
    .ready(rdy_rea),
    .pulse_n(rea_n)
  ); // R8

  // In sign mode a pulse may only start once the sign pin already shows its direction;
  // a mismatch costs one word period while the sign settles.
  always @* begin
    fire_act = 1'b0;
    fire_rea = 1'b0;
    next_sign = energy_sign;
    if (second_output_select == `EPO_E2_SIGN) begin
      fire_act = rdy_act && !no_load && (energy_sign == act_pos); // R2 R16
      fire_rea = rdy_rea && (energy_sign == rea_pos); // R9 R17
      // Sign moves only in a cycle where no active or reactive pulse falls
      if (!fire_act && !fire_rea) begin
        if (rdy_act && !no_load) begin
          next_sign = act_pos; // R2
        end else if (rdy_rea) begin
          next_sign = rea_pos; // R9
        end
      end
    end else begin
      fire_act = rdy_act && !no_load; // R16
      fire_rea = rdy_rea;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      energy_sign <= `EPO_SIGN_POS;
    end else begin
      energy_sign <= next_sign;
    end
  end

  // Pins registered together so a fall and the sign level stay aligned
  always @(posedge core_clk) begin
    if (srst) begin
      active_energy_pulse_pin <= `EPO_PIN_IDLE;
      sign_or_apparent_pin <= `EPO_PIN_IDLE;
      third_energy_output_pin <= `EPO_PIN_IDLE;
    end else begin
      active_energy_pulse_pin <= act_n; // R1
      if (second_output_select == `EPO_E2_APPARENT) begin
        sign_or_apparent_pin <= app_n; // R5
      end else begin
        sign_or_apparent_pin <= energy_sign; // R17
      end
      case (third_output_select)
        `EPO_E3_REACTIVE: third_energy_output_pin <= rea_n; // R8
        `EPO_E3_SUPPLY: third_energy_output_pin <= supply_sync; // R11
        `EPO_E3_VSIGN: begin
          third_energy_output_pin <= ~voltage_sample[`EPO_SIGN_BIT]; // R10
        end
        `EPO_E3_APPARENT: third_energy_output_pin <= app_n; // R6
        default: third_energy_output_pin <= `EPO_PIN_IDLE;
      endcase
    end
  end

  assign sag_mag[0] = abs_val(voltage_sample);
  assign sag_mag[1] = abs_val(current_sample);
  assign sag_level[0] = voltage_sag_threshold;
  assign sag_level[1] = current_fault_threshold;
  assign sag_win[0] = voltage_sag_window;
  assign sag_win[1] = current_fault_window;
  assign sag_clear = {current_fault_clear, voltage_sag_clear};

  // One sample per word period; counts restart when a setting is zero
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sag
      reg [WINDOW_W-1:0] seen;
      reg [WINDOW_W-1:0] below;
      reg hit;
      wire armed;
      wire is_below;
      wire [WINDOW_W:0] below_next;
      assign armed = (sag_level[gi] != 0) && (sag_win[gi] != 0); // R14
      assign is_below = sag_mag[gi] < sag_level[gi]; // R15
      assign below_next = {1'b0, below} + {{WINDOW_W{1'b0}}, is_below};
      assign sag_event[gi] = hit;
      always @(posedge core_clk) begin
        if (srst || !armed) begin
          seen <= {WINDOW_W{1'b0}};
          below <= {WINDOW_W{1'b0}};
          hit <= 1'b0;
        end else begin
          hit <= 1'b0;
          if (owr_tick) begin
            if (seen == sag_win[gi] - 1'b1) begin // R15
              seen <= {WINDOW_W{1'b0}};
              below <= {WINDOW_W{1'b0}};
              // More than half: twice the count beats the window
              hit <= ({below_next, 1'b0} > {2'b00, sag_win[gi]}); // R13
            end else begin
              seen <= seen + 1'b1;
              below <= below_next[WINDOW_W-1:0];
            end
          end
        end
      end
    end
  endgenerate

  // Sticky flags; a new event beats a clear in the same cycle
  always @(posedge core_clk) begin
    if (srst) begin
      voltage_sag_flag <= `EPO_FLAG_RST;
      current_fault_flag <= `EPO_FLAG_RST;
    end else begin
      if (sag_event[0]) begin
        voltage_sag_flag <= 1'b1; // R12
      end else if (sag_clear[0]) begin
        voltage_sag_flag <= 1'b0;
      end
      if (sag_event[1]) begin
        current_fault_flag <= 1'b1; // R12
      end else if (sag_clear[1]) begin
        current_fault_flag <= 1'b0;
      end
    end
  end

endmodule // energy_pulse_output

// ==== bench/energy_pulse_output_checker.sv ====
// Concurrent checks on the energy pulse output ports
`timescale 1ns/10ps
module energy_pulse_checker #(
  parameter CLK_DIV_K = 4'h1,
  parameter DATA_W = 24,
  parameter WIDTH_W = 16,
  parameter WINDOW_W = 16
) (
  // Clock, reset and modes
  input wire core_clk,
  input wire srst,
  input wire second_output_select,
  input wire [1:0] third_output_select,
  input wire [WIDTH_W-1:0] pulse_width_count,
  // Levels and data
  input wire [DATA_W-1:0] no_load_threshold,
  input wire [DATA_W-1:0] voltage_sag_threshold,
  input wire [WINDOW_W-1:0] voltage_sag_window,
  input wire [DATA_W-1:0] active_power_result,
  input wire [DATA_W-1:0] voltage_sample,
  input wire supply_monitor_input,
  // Outputs
  input wire voltage_sag_flag,
  input wire active_energy_pulse_pin,
  input wire sign_or_apparent_pin,
  input wire third_energy_output_pin
);
  // Gap saturates so a long idle never wraps into a false hit
  logic act_q;
  logic [11:0] gap;
  logic [31:0] low_len;
  wire fall_now = act_q && !active_energy_pulse_pin;
  wire [DATA_W-1:0] mag = active_power_result[DATA_W-1] ?
    -active_power_result : active_power_result;
  wire [31:0] low_exp = (pulse_width_count == 0 ? 32'h1 :
    32'(pulse_width_count)) * 32'h400 * CLK_DIV_K;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_q <= 1'b1;
      gap <= 12'hfff;
      low_len <= 32'h0;
    end else begin
      act_q <= active_energy_pulse_pin;
      gap <= fall_now ? 12'h1 : (gap == 12'hfff ? gap : gap + 12'h1);
      low_len <= active_energy_pulse_pin ? 32'h0 : low_len + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence supply_held;
    (third_output_select == 2'b01 && $stable(supply_monitor_input))[*6];
  endsequence
  pulse_spacing_a:
    assert property (fall_now |-> gap >= 12'h800)
      else $error("active pulses too close");
  low_time_a:
    assert property (!act_q && active_energy_pulse_pin |-> low_len == low_exp)
      else $error("active low time wrong");
  sign_hold_a:
    assert property ($fell(active_energy_pulse_pin) && !second_output_select
      |-> $stable(sign_or_apparent_pin)) else $error("sign moved at fall");
  no_load_a:
    assert property ($fell(active_energy_pulse_pin) |->
      $past(mag >= no_load_threshold, 2)) else $error("pulse under no load");
  volt_sign_a:
    assert property (!$past(srst) && $past(third_output_select) == 2'b10 |->
      third_energy_output_pin == !$past(voltage_sample[DATA_W-1]))
      else $error("voltage sign wrong");
  supply_mon_a:
    assert property (supply_held |->
      third_energy_output_pin == supply_monitor_input)
      else $error("supply monitor wrong");
  sag_config_a:
    assert property ($rose(voltage_sag_flag) |->
      $past(voltage_sag_threshold != 0 && voltage_sag_window != 0, 2))
      else $error("sag flag while unconfigured");
  apparent_both_a:
    assert property (!$past(srst) && $past(second_output_select) &&
      $past(third_output_select) == 2'b11 |->
      sign_or_apparent_pin == third_energy_output_pin)
      else $error("apparent pins differ");
endmodule // energy_pulse_checker

bind energy_pulse_output energy_pulse_checker #(.CLK_DIV_K(CLK_DIV_K),
  .DATA_W(DATA_W), .WIDTH_W(WIDTH_W), .WINDOW_W(WINDOW_W)) chk (
  .core_clk, .srst, .second_output_select, .third_output_select,
  .pulse_width_count, .no_load_threshold, .voltage_sag_threshold,
  .voltage_sag_window, .active_power_result, .voltage_sample,
  .supply_monitor_input, .voltage_sag_flag, .active_energy_pulse_pin,
  .sign_or_apparent_pin, .third_energy_output_pin);

// ==== bench/energy_pulse_counter.sv ====
// Pulse counter model standing at the energy pins
`timescale 1ns/10ps
module energy_pulse_counter (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Energy pins
  input wire active_energy_pulse_pin,
  input wire sign_or_apparent_pin,
  input wire third_energy_output_pin,
  // Counts of falls, and falls seen with the sign pin low
  output logic [7:0] act_cnt,
  output logic [7:0] act_neg,
  output logic [7:0] sgn_cnt,
  output logic [7:0] thr_cnt,
  output logic [7:0] thr_neg
);
  logic [2:0] prev;
  always @(posedge core_clk) begin
    if (srst) begin
      prev <= 3'b111;
      act_cnt <= 8'h0;
      act_neg <= 8'h0;
      sgn_cnt <= 8'h0;
      thr_cnt <= 8'h0;
      thr_neg <= 8'h0;
    end else begin
      prev <= {active_energy_pulse_pin, sign_or_apparent_pin,
        third_energy_output_pin};
      if (prev[2] && !active_energy_pulse_pin) begin
        act_cnt <= act_cnt + 8'h1;
        act_neg <= act_neg + {7'h0, !sign_or_apparent_pin};
      end
      if (prev[1] && !sign_or_apparent_pin) begin
        sgn_cnt <= sgn_cnt + 8'h1;
      end
      if (prev[0] && !third_energy_output_pin) begin
        thr_cnt <= thr_cnt + 8'h1;
        thr_neg <= thr_neg + {7'h0, !sign_or_apparent_pin};
      end
    end
  end
endmodule // energy_pulse_counter

// ==== bench/energy_pulse_output_tb.sv ====
// Self-checking testbench for the energy pulse output block
`timescale 1ns/10ps
module energy_pulse_output_tb;
  logic core_clk, srst, second_output_select, supply_monitor_input;
  logic voltage_sag_clear, current_fault_clear;
  logic [1:0] third_output_select;
  logic [15:0] pulse_width_count, voltage_sag_window, current_fault_window;
  logic [23:0] active_power_result, apparent_power_result;
  logic [23:0] reactive_power_result, no_load_threshold;
  logic [23:0] voltage_sag_threshold, current_fault_threshold;
  logic [23:0] voltage_sample, current_sample;
  wire voltage_sag_flag, current_fault_flag, active_energy_pulse_pin;
  wire sign_or_apparent_pin, third_energy_output_pin;
  wire [7:0] act_cnt, act_neg, sgn_cnt, thr_cnt, thr_neg;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Full scale rate so one half scale power gives a pulse every 4 ticks
  energy_pulse_output uut (.core_clk, .srst, .second_output_select,
    .third_output_select, .pulse_rate_scale(24'h800000), .pulse_width_count,
    .no_load_threshold, .voltage_sag_threshold, .voltage_sag_window,
    .current_fault_threshold, .current_fault_window, .active_power_result,
    .apparent_power_result, .reactive_power_result, .voltage_sample,
    .current_sample, .supply_monitor_input, .voltage_sag_clear,
    .current_fault_clear, .voltage_sag_flag, .current_fault_flag,
    .active_energy_pulse_pin, .sign_or_apparent_pin,
    .third_energy_output_pin);
  energy_pulse_counter far (.core_clk, .srst, .active_energy_pulse_pin,
    .sign_or_apparent_pin, .third_energy_output_pin, .act_cnt, .act_neg,
    .sgn_cnt, .thr_cnt, .thr_neg);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task ticks(input int n);
    repeat (n * 1024) @(negedge core_clk);
  endtask
  task restart;
    srst = 1'b1;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
  endtask
  task cfg(input logic m2, input logic [1:0] m3, input logic [23:0] pa,
    input logic [23:0] qa, input logic [23:0] sa, input logic [23:0] ta);
    second_output_select = m2;
    third_output_select = m3;
    active_power_result = pa;
    reactive_power_result = qa;
    apparent_power_result = sa;
    no_load_threshold = ta;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 75000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    srst = 1'b1;
    cfg(1'b0, 2'b00, 24'h0, 24'h0, 24'h0, 24'h0);
    {supply_monitor_input, voltage_sag_clear, current_fault_clear} = 3'h0;
    pulse_width_count = 16'h1;
    {voltage_sag_window, current_fault_window} = 32'h0;
    {voltage_sag_threshold, current_fault_threshold} = 48'h0;
    {voltage_sample, current_sample} = 48'h0;
    restart;
    cfg(1'b0, 2'b00, 24'hc00000, 24'h400000, 24'h0, 24'h0);
    ticks(13);
    check(act_cnt >= 8'h2 && act_cnt <= 8'h3, 32'h1);
    check(act_neg, act_cnt);
    check(thr_cnt >= 8'h1 && thr_cnt <= 8'h3, 32'h1);
    check(thr_neg, 32'h0);
    restart;
    cfg(1'b0, 2'b00, 24'h400000, 24'h0, 24'h0, 24'h400001);
    ticks(9);
    check(act_cnt, 32'h0);
    no_load_threshold = 24'h400000;
    ticks(9);
    check(act_cnt >= 8'h1 && act_cnt <= 8'h4, 32'h1);
    restart;
    pulse_width_count = 16'h2;
    cfg(1'b1, 2'b11, 24'h0, 24'h0, 24'h400000, 24'h0);
    ticks(13);
    check(sgn_cnt >= 8'h2 && sgn_cnt <= 8'h3, 32'h1);
    check(thr_cnt, sgn_cnt);
    check(act_cnt, 32'h0);
    third_output_select = 2'b10;
    voltage_sample = 24'h800000;
    repeat (2) @(negedge core_clk);
    check(third_energy_output_pin, 32'h0);
    voltage_sample = 24'h000001;
    repeat (2) @(negedge core_clk);
    check(third_energy_output_pin, 32'h1);
    third_output_select = 2'b01;
    repeat (6) @(negedge core_clk);
    check(third_energy_output_pin, 32'h0);
    supply_monitor_input = 1'b1;
    repeat (6) @(negedge core_clk);
    check(third_energy_output_pin, 32'h1);
    restart;
    cfg(1'b0, 2'b00, 24'h0, 24'h0, 24'h0, 24'h0);
    // Negative small sample shows the level is taken on the magnitude
    {voltage_sag_threshold, voltage_sag_window} = {24'h100000, 16'h4};
    {current_fault_threshold, current_sample} = {24'h100000, 24'h10};
    voltage_sample = 24'hfffff0;
    ticks(6);
    check(voltage_sag_flag, 32'h1);
    check(current_fault_flag, 32'h0);
    current_fault_window = 16'h4;
    voltage_sample = 24'hc00000;
    ticks(5);
    voltage_sag_clear = 1'b1;
    @(negedge core_clk);
    voltage_sag_clear = 1'b0;
    ticks(5);
    check(voltage_sag_flag, 32'h0);
    check(current_fault_flag, 32'h1);
    report_and_stop;
  end
endmodule // energy_pulse_output_tb
